// *** verilog/fspc_core.v ***
// fspc_core.v: self-programming control and status with wishbone slave
// assumes classic wishbone master on clk_i; core strobes are clk_i pulses
`timescale 1ns/1ps
`include "fspc_regs.vh"
module fspc_core #(
  parameter PROG_CYCLES = `FSPC_PROG_CYCLES
) (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire        global_irq_en_i,
  input  wire        eeprom_write_busy_i,
  input  wire [1:0]  boot_size_fuse_i,
  output wire        ready_irq_o,
  output wire        core_stall_o,
  output wire        rww_blocked_o,
  output reg         flash_erase_o,
  output reg         flash_write_o,
  output reg         lock_write_o,
  output reg  [8:0]  page_select_o,
  output wire [15:0] buf_rdata_o,
  output wire [15:0] boot_start_o
);
  // software-visible registers
  reg [7:0]  csr_q;
  reg [15:0] zptr_q;
  reg        zext_q;
  reg [15:0] data_q;
  reg [7:0]  lock_q;
  reg [7:0]  fuse_lo_q;
  reg [7:0]  fuse_hi_q;
  reg [7:0]  fuse_ext_q;
  reg [7:0]  rdata_q;
  reg [2:0]  win_q;
  reg        op_no_read_while_write_section_q;
  reg        loading_q;
  reg        ee_q1;
  reg        ee_q2;
  wire       op_busy;
  wire       op_done;
  wire       buf_clr;
  reg        buf_wr;
  reg        op_start;

  // two-flop sync for the eeprom busy level
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ee_q1 <= 1'b0;
      ee_q2 <= 1'b0;
    end
    else
    begin
      ee_q1 <= eeprom_write_busy_i;
      ee_q2 <= ee_q1;
    end
  end

  function [15:0] boot_start;
    input [1:0] sz;
    begin
      case (sz)
        2'b11:   boot_start = 16'hfe00;
        2'b10:   boot_start = 16'hfc00;
        2'b01:   boot_start = 16'hf800;
        default: boot_start = 16'hf000;
      endcase
    end
  endfunction

  function in_no_read_while_write_section;
    input       ext;
    input [7:0] hi;
    begin
      // page number is word address >> 7, so the limit page is f000 >> 7
      in_no_read_while_write_section = ({7'h0, ext, hi} >= (`FSPC_RWW_LIMIT >> 7));
    end
  endfunction

  assign boot_start_o = boot_start(boot_size_fuse_i);

  // wishbone decode
  wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wb_wr  = wb_req & wb_we_i & wb_sel_i[0];
  wire csr_wr = wb_wr & (wb_adr_i == `FSPC_ADDR_CSR);
  wire cmd_wr = wb_wr & (wb_adr_i == `FSPC_ADDR_CMD);
  wire spm_i  = cmd_wr & wb_dat_i[0];
  wire lpm_i  = cmd_wr & wb_dat_i[1];
  wire [4:0] pat    = csr_q[4:0];
  wire [4:0] wr_pat = wb_dat_i[4:0];
  wire [6:0] word_sel = zptr_q[7:1];
  wire [8:0] page_sel = {zext_q, zptr_q[15:8]};
  wire pat_ok = (wr_pat == `FSPC_PAT_REEN) || (wr_pat == `FSPC_PAT_LOCK) ||
                (wr_pat == `FSPC_PAT_WRT)  || (wr_pat == `FSPC_PAT_ERS) ||
                (wr_pat == `FSPC_PAT_FILL);
  wire win_open = (win_q != 3'd0) && !op_busy;

  // register writes and command sequencing
  always @*
  begin
    buf_wr   = 1'b0;
    op_start = 1'b0;
    if (spm_i && win_open && csr_q[0] && !ee_q2)
    begin
      case (pat)
        `FSPC_PAT_FILL: buf_wr   = 1'b1;
        `FSPC_PAT_WRT:  op_start = 1'b1;
        `FSPC_PAT_ERS:  op_start = 1'b1;
        `FSPC_PAT_LOCK: op_start = 1'b1;
        default:        op_start = 1'b0;
      endcase
    end
  end
  // reenable while loading throws away the loaded data
  assign buf_clr = (csr_wr && wb_dat_i[4] && loading_q) ||
                   (flash_write_o);

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      csr_q         <= `FSPC_CSR_RESET;
      zptr_q        <= 16'h0;
      zext_q        <= 1'b0;
      data_q        <= 16'h0;
      lock_q        <= 8'hff;
      fuse_lo_q     <= 8'hff;
      fuse_hi_q     <= 8'hff;
      fuse_ext_q    <= 8'hff;
      rdata_q       <= 8'h0;
      win_q         <= 3'd0;
      op_no_read_while_write_section_q     <= 1'b0;
      loading_q     <= 1'b0;
      flash_erase_o <= 1'b0;
      flash_write_o <= 1'b0;
      lock_write_o  <= 1'b0;
      page_select_o <= 9'h0;
    end
    else
    begin
      flash_erase_o <= 1'b0;
      flash_write_o <= 1'b0;
      lock_write_o  <= 1'b0;
      // window counts from the cycle the master sees ack
      if (win_q != 3'd0 && !op_busy && !wb_ack_o)
        win_q <= win_q - 3'd1;
      if (!op_busy && !op_start && !wb_ack_o && win_q == 3'd1)
        csr_q[4:0] <= 5'h0;
      if (csr_wr)
      begin
        csr_q[`FSPC_BIT_IE] <= wb_dat_i[7];
        if (pat_ok && !op_busy && !ee_q2)
        begin
          csr_q[4:0] <= wr_pat;
          win_q      <= `FSPC_SPM_WINDOW;
        end
        if (wb_dat_i[4] && loading_q)
          loading_q <= 1'b0;
      end
      if (wb_wr && wb_adr_i == `FSPC_ADDR_ZPTR)
      begin
        zptr_q <= wb_dat_i[15:0];
        zext_q <= wb_dat_i[16];
      end
      if (wb_wr && wb_adr_i == `FSPC_ADDR_DATA)
        data_q <= wb_dat_i[15:0];
      if (wb_wr && wb_adr_i == `FSPC_ADDR_FUSE)
      begin
        fuse_lo_q  <= wb_dat_i[7:0];
        fuse_hi_q  <= wb_dat_i[15:8];
        fuse_ext_q <= wb_dat_i[23:16];
      end
      if (buf_wr)
      begin
        loading_q    <= 1'b1;
        csr_q[6]     <= 1'b0;
        csr_q[4:0]   <= 5'h0;
        win_q        <= 3'd0;
      end
      if (spm_i && win_open && pat == `FSPC_PAT_REEN && !ee_q2)
      begin
        csr_q[6]   <= 1'b0;
        csr_q[4:0] <= 5'h0;
        win_q      <= 3'd0;
      end
      if (op_start)
      begin
        win_q         <= 3'd0;
        page_select_o <= page_sel;
        op_no_read_while_write_section_q     <= in_no_read_while_write_section(zext_q, zptr_q[15:8]);
        if (pat == `FSPC_PAT_LOCK)
          lock_write_o <= 1'b1;
        else
        begin
          flash_erase_o <= (pat == `FSPC_PAT_ERS);
          flash_write_o <= (pat == `FSPC_PAT_WRT);
          loading_q     <= 1'b0;
          if (!in_no_read_while_write_section(zext_q, zptr_q[15:8]))
            csr_q[6] <= 1'b1;
        end
      end
      if (lock_write_o)
        lock_q <= lock_q & (data_q[7:0] | 8'hc0);
      if (op_done)
        csr_q[4:0] <= 5'h0;
      if (lpm_i && pat == `FSPC_PAT_LOCK && win_q > 3'd1 && !ee_q2)
      begin
        case (zptr_q[1:0])
          2'b01:   rdata_q <= lock_q;
          2'b00:   rdata_q <= fuse_lo_q;
          2'b11:   rdata_q <= fuse_hi_q;
          default: rdata_q <= fuse_ext_q;
        endcase
        csr_q[4:0] <= 5'h0;
        win_q      <= 3'd0;
      end
    end
  end

  fspc_op_timer #(
    .CYCLES (PROG_CYCLES)
  ) u_timer (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_i (op_start),
    .busy_o  (op_busy),
    .done_o  (op_done)
  );

  fspc_page_buffer u_buf (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .wr_i    (buf_wr),
    .clr_i   (buf_clr),
    .waddr_i (word_sel),
    .wdata_i (data_q),
    .raddr_i (word_sel),
    .rdata_o (buf_rdata_o)
  );

  assign ready_irq_o   = csr_q[7] & global_irq_en_i & ~csr_q[0];
  assign core_stall_o  = op_busy & op_no_read_while_write_section_q;
  assign rww_blocked_o = csr_q[6];

  // read mux and ack
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end
    else
    begin
      wb_ack_o <= wb_req;
      case (wb_adr_i)
        `FSPC_ADDR_CSR:    wb_dat_o <= {24'h0, csr_q & 8'hdf};
        `FSPC_ADDR_ZPTR:   wb_dat_o <= {15'h0, zext_q, zptr_q};
        `FSPC_ADDR_DATA:   wb_dat_o <= {16'h0, data_q};
        `FSPC_ADDR_STATUS: wb_dat_o <= {25'h0, win_q, ee_q2, loading_q,
                                        core_stall_o, op_busy};
        `FSPC_ADDR_RDATA:  wb_dat_o <= {24'h0, rdata_q};
        `FSPC_ADDR_LOCK:   wb_dat_o <= {24'h0, lock_q};
        `FSPC_ADDR_FUSE:   wb_dat_o <= {8'h0, fuse_ext_q, fuse_hi_q, fuse_lo_q};
        `FSPC_ADDR_BUFRD:  wb_dat_o <= {16'h0, buf_rdata_o};
        default:           wb_dat_o <= 32'h0;
      endcase
    end
  end
endmodule // fspc_core

// *** verilog/fspc_regs.vh ***
// fspc_regs.vh: offsets, field positions, reset values and timing counts
// for the self-programming control block; assumes 125 MHz clk_i
// Operation
// - boot size fuse picks boot start address
// - below F000 is read-while-write section
// - 128-word pages, word Z7:Z1, page Z16:Z8
// - ready request while enabled, global, enable clear
// - busy flag set on section erase/write
// - busy cleared by reenable or buffer load
// - reenable command ignored while operation busy
// - reenable during buffer load discards buffer
// - lock-bit set programs lock bits from R0
// - load within three cycles reads lock/fuse
// - page write copies buffer to page
// - page erase clears addressed page
// - stall core during no-read-while-write operation
// - enable alone stores R0 into buffer
// - four-cycle window, enable held while busy
// - only documented patterns act
// - eeprom write blocks programming and read-back
// - pointer selects lock or fuse byte
// - programmed bits read zero
// - operations take 3.7 to 4.5 ms
`ifndef FSPC_REGS_VH
`define FSPC_REGS_VH
`define FSPC_ADDR_CSR       8'h00
`define FSPC_ADDR_ZPTR      8'h04
`define FSPC_ADDR_DATA      8'h08
`define FSPC_ADDR_CMD       8'h0c
`define FSPC_ADDR_STATUS    8'h10
`define FSPC_ADDR_RDATA     8'h14
`define FSPC_ADDR_LOCK      8'h18
`define FSPC_ADDR_FUSE      8'h1c
`define FSPC_ADDR_BUFRD     8'h20
`define FSPC_BIT_IE         7
`define FSPC_BIT_BUSY       6
`define FSPC_BIT_REEN       4
`define FSPC_BIT_LOCK       3
`define FSPC_BIT_WRT        2
`define FSPC_BIT_ERS        1
`define FSPC_BIT_EN         0
`define FSPC_CSR_RESET      8'h00
`define FSPC_PAT_REEN       5'h11
`define FSPC_PAT_LOCK       5'h09
`define FSPC_PAT_WRT        5'h05
`define FSPC_PAT_ERS        5'h03
`define FSPC_PAT_FILL       5'h01
`define FSPC_RWW_LIMIT      16'hf000
`define FSPC_SPM_WINDOW     3'd4
`define FSPC_LPM_WINDOW     3'd3
`define FSPC_CLK_MHZ        125
`define FSPC_PROG_TIME_US   4100
`define FSPC_PROG_CYCLES    (`FSPC_PROG_TIME_US * `FSPC_CLK_MHZ)
`define FSPC_PAGE_WORDS     128
`endif

// *** verilog/fspc_page_buffer.v ***
// fspc_page_buffer.v: temporary page buffer, 128 words of 16 bits
// assumes single clock, synchronous clear of valid flags
`timescale 1ns/1ps
module fspc_page_buffer (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        wr_i,
  input  wire        clr_i,
  input  wire [6:0]  waddr_i,
  input  wire [15:0] wdata_i,
  input  wire [6:0]  raddr_i,
  output reg  [15:0] rdata_o
);
  reg [15:0]  mem [0:127];
  reg [127:0] valid_q;
  always @(posedge clk_i)
  begin
    if (rst_i || clr_i)
      valid_q <= 128'h0;
    else if (wr_i)
      valid_q[waddr_i] <= 1'b1;
    if (wr_i)
      mem[waddr_i] <= wdata_i;
  end
  // unloaded words read as erased
  always @(posedge clk_i)
  begin
    if (rst_i)
      rdata_o <= 16'hffff;
    else
      rdata_o <= valid_q[raddr_i] ? mem[raddr_i] : 16'hffff;
  end
endmodule // fspc_page_buffer

// *** verilog/fspc_op_timer.v ***
// fspc_op_timer.v: counts the erase/write/lock programming time
// assumes start_i is a one-cycle pulse on clk_i
`timescale 1ns/1ps
`include "fspc_regs.vh"
module fspc_op_timer #(
  parameter CYCLES = `FSPC_PROG_CYCLES
) (
  input  wire clk_i,
  input  wire rst_i,
  input  wire start_i,
  output reg  busy_o,
  output reg  done_o
);
  reg [19:0] cnt_q;
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_q  <= 20'h0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end
    else
    begin
      done_o <= 1'b0;
      if (start_i)
      begin
        cnt_q  <= CYCLES[19:0] - 20'h1;
        busy_o <= 1'b1;
      end
      else if (busy_o)
      begin
        if (cnt_q == 20'h0)
        begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
        end
        else
          cnt_q <= cnt_q - 20'h1;
      end
    end
  end
endmodule // fspc_op_timer

// *** verification/fspc_core_model.sv ***
// fspc_core_model.sv: processor core model issuing store and load commands
// assumes a classic wishbone slave on clk_i that answers with ack
`timescale 1ns/1ps
module fspc_core_model (
  input  wire        clk_i,
  input  wire        ack_i,
  input  wire [31:0] dat_i,
  output reg         cyc_o,
  output reg         stb_o,
  output reg         we_o,
  output reg  [7:0]  adr_o,
  output reg  [3:0]  sel_o,
  output reg  [31:0] dat_o
);
  initial
  begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o  = 1'b0;
    adr_o = 8'h00;
    sel_o = 4'hf;
    dat_o = 32'h00000000;
  end
  // one classic cycle, held until ack is sampled high
  task xfer(input w, input [7:0] a, input [31:0] d, output [31:0] q);
  begin
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o  <= w;
    adr_o <= a;
    dat_o <= d;
    @(posedge clk_i);
    while (ack_i !== 1'b1)
    begin
      @(posedge clk_i);
    end
    q = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
  end
  endtask
  // pointer, data, control write, then the instruction strobe
  task op(input [16:0] z, input [15:0] d, input [7:0] c, input [1:0] ins);
    reg [31:0] q;
  begin
    xfer(1'b1, 8'h04, ins[0] ? {15'h0, z[16:1], 1'b0} : {15'h0, z}, q);
    xfer(1'b1, 8'h08, {16'h0, d}, q);
    xfer(1'b1, 8'h00, {24'h0, c}, q);
    xfer(1'b1, 8'h0c, {30'h0, ins}, q);
  end
  endtask
endmodule // fspc_core_model

// *** verification/fspc_core_chk.sv ***
// fspc_core_chk.sv: port assertions for the self-programming control block
// assumes one clock domain, synchronous active-high reset
`timescale 1ns/1ps
module fspc_core_chk #(
  parameter PROG_CYCLES = 20
) (
  input wire        clk_i,
  input wire        rst_i,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_ack_o,
  input wire        global_irq_en_i,
  input wire        eeprom_write_busy_i,
  input wire [1:0]  boot_size_fuse_i,
  input wire        ready_irq_o,
  input wire        core_stall_o,
  input wire        flash_erase_o,
  input wire        flash_write_o,
  input wire        lock_write_o,
  input wire        rww_blocked_o,
  input wire [8:0]  page_select_o,
  input wire [15:0] boot_start_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire start = flash_erase_o | flash_write_o | lock_write_o;
  wire pgop  = flash_erase_o | flash_write_o;
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_quiet; !start [*8]; endsequence
  chk_ack_next: assert property (s_req |=> wb_ack_o) else $error("ack missing");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  chk_boot_map: assert property (boot_start_o == 16'h0 - (16'h1000 >> boot_size_fuse_i))
    else $error("boot start wrong");
  chk_irq_gate: assert property (ready_irq_o |-> global_irq_en_i && !start)
    else $error("ready request wrong");
  chk_op_single: assert property (start |-> $onehot({flash_erase_o, flash_write_o, lock_write_o}) ##1 s_quiet)
    else $error("operation start repeated");
  chk_busy_set: assert property (pgop && page_select_o < 9'h1e0 |-> ##[0:2] rww_blocked_o)
    else $error("busy flag not set");
  chk_stall_no_read_while_write_section: assert property (pgop && page_select_o >= 9'h1e0 |-> ##[0:2] core_stall_o [*4])
    else $error("core not stalled");
  chk_stall_page: assert property (core_stall_o |-> page_select_o >= 9'h1e0)
    else $error("stall outside section");
  chk_ee_block: assert property (eeprom_write_busy_i [*4] |-> !start)
    else $error("operation during eeprom write");
endmodule // fspc_core_chk
bind fspc_core fspc_core_chk #(.PROG_CYCLES(PROG_CYCLES)) chk_u (.clk_i, .rst_i, .wb_cyc_i,
  .wb_stb_i, .wb_ack_o, .global_irq_en_i, .eeprom_write_busy_i, .boot_size_fuse_i,
  .ready_irq_o, .core_stall_o, .flash_erase_o, .flash_write_o, .lock_write_o,
  .rww_blocked_o, .page_select_o, .boot_start_o);

// *** verification/fspc_core_tb.sv ***
// fspc_core_tb.sv: self-checking bench for the self-programming control block
// assumes the core model drives the bus and PROG_CYCLES is shortened to 20
`timescale 1ns/1ps
module fspc_core_tb;
  reg         clk_i = 1'b0;
  reg         rst_i = 1'b1;
  reg         gie   = 1'b0;
  reg         ee    = 1'b0;
  reg  [1:0]  fz    = 2'b00;
  wire        cyc, stb, we, ack, irq, stall, read_while_write_section, ers, wrt, lck;
  wire [7:0]  adr;
  wire [3:0]  sel;
  wire [31:0] wdat, rdat;
  wire [8:0]  page;
  wire [15:0] bufd, boot;
  reg  [31:0] v;
  integer     n_mismatch = 0;
  integer     n_checks   = 0;
  integer     i;
  always #4 clk_i = ~clk_i;
  fspc_core #(.PROG_CYCLES(20)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .global_irq_en_i(gie), .eeprom_write_busy_i(ee),
    .boot_size_fuse_i(fz), .ready_irq_o(irq), .core_stall_o(stall),
    .rww_blocked_o(read_while_write_section), .flash_erase_o(ers), .flash_write_o(wrt), .lock_write_o(lck),
    .page_select_o(page), .buf_rdata_o(bufd), .boot_start_o(boot));
  fspc_core_model cpu_u (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc),
    .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));
  task chk(input string nm, input [31:0] got, input [31:0] exp);
  begin
    n_checks = n_checks + 1;
    if (got !== exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  end
  endtask
  task rc(input [7:0] a, input [31:0] e);
  begin
    cpu_u.xfer(1'b0, a, 32'h0, v);
    chk($sformatf("reg %h", a), v, e);
  end
  endtask
  // poll the timer busy status until the operation ends
  task idle;
    integer k;
  begin
    k = 0;
    v = 1;
    while (v[0] === 1'b1 && k < 100)
    begin
      cpu_u.xfer(1'b0, 8'h10, 32'h0, v);
      k = k + 1;
    end
  end
  endtask
  task print_verdict;
  begin
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  end
  endtask
  initial
  begin
    #(8 * 20000);
    n_mismatch = n_mismatch + 1;
    print_verdict;
  end
  initial
  begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    for (i = 0; i < 4; i = i + 1)
    begin
      @(posedge clk_i);
      fz <= i[1:0];
      @(negedge clk_i);
      chk("boot", boot, 32'h10000 - (32'h1000 >> i));
    end
    rc(8'h00, 32'h00);
    cpu_u.xfer(1'b1, 8'h00, 32'hff, v);
    rc(8'h00, 32'h80);
    rc(8'h40, 32'h00);
    gie <= 1'b1;
    @(negedge clk_i);
    chk("irq", irq, 1);
    cpu_u.op(17'h00006, 16'h1234, 8'h81, 2'b01);
    repeat (2) @(negedge clk_i);
    chk("buf", bufd, 32'h1234);
    rc(8'h00, 32'h80);
    cpu_u.xfer(1'b1, 8'h00, 32'h81, v);
    repeat (8) @(posedge clk_i);
    rc(8'h00, 32'h80);
    cpu_u.op(17'h00006, 16'h0, 8'h91, 2'b01);
    repeat (2) @(negedge clk_i);
    chk("buf", bufd, 32'hffff);
    cpu_u.op(17'h00100, 16'h0, 8'h83, 2'b01);
    @(negedge clk_i);
    chk("rww", read_while_write_section, 1);
    chk("page", page, 32'h001);
    chk("irq", irq, 0);
    rc(8'h00, 32'hc3);
    cpu_u.xfer(1'b1, 8'h00, 32'h91, v);
    idle;
    rc(8'h00, 32'hc0);
    cpu_u.op(17'h00000, 16'h0, 8'h91, 2'b01);
    @(negedge clk_i);
    chk("rww", read_while_write_section, 0);
    cpu_u.op(17'h00100, 16'h0, 8'h83, 2'b01);
    idle;
    cpu_u.op(17'h00006, 16'h5555, 8'h81, 2'b01);
    @(negedge clk_i);
    chk("rww", read_while_write_section, 0);
    cpu_u.op(17'h1f000, 16'h0, 8'h85, 2'b01);
    @(negedge clk_i);
    chk("stall", stall, 1);
    chk("page", page, 32'h1f0);
    idle;
    chk("rww", read_while_write_section, 0);
    cpu_u.xfer(1'b1, 8'h1c, 32'h00c35a3c, v);
    for (i = 0; i < 4; i = i + 1)
    begin
      cpu_u.op(i, 16'h0, 8'h89, 2'b10);
      rc(8'h14, (32'h5ac3ff3c >> (8 * i)) & 32'hff);
    end
    cpu_u.op(17'h00000, 16'h0033, 8'h89, 2'b01);
    idle;
    rc(8'h18, 32'hf3);
    ee <= 1'b1;
    repeat (4) @(posedge clk_i);
    cpu_u.op(17'h00100, 16'h0, 8'h83, 2'b01);
    rc(8'h00, 32'h80);
    ee <= 1'b0;
    gie <= 1'b0;
    @(negedge clk_i);
    chk("irq", irq, 0);
    print_verdict;
  end
endmodule // fspc_core_tb
